// >>> verilog/gp56_ports.v
// two 8-bit gpio ports with wishbone register access
`timescale 1ns/1ps
`include "gp56_defines.vh"

// Function
// - Each port five pin is an output when its direction bit is 1 and an input when 0.
// - Port five pin 6 always feeds interrupt 6 and the timer event, pin 5 interrupt 5 and the converter trigger.
// - Port five pins float in reset, hold in sleep and subsleep, float in standby and watch, work otherwise.
// - A floating port five pin with its pull-up on is driven high in standby and watch.
// - A port five pull-up is on only when the direction bit is 0 and the pull-up bit is 1.
// - All port five pull-ups are off after reset.
// - The port six latch holds one bit per pin and clears to zero on reset.
// - Reading port six returns the latch bit for every output pin.
// - Reading port six returns the sampled pin level for every input pin.
// - A port six pin drives its latch bit when its direction bit is 1 and is an input otherwise.
// - The port six direction register is write only and reads as all ones.
// - The port six direction register clears to zero on reset.
// - Reading port five returns the latch for outputs and the sampled pin for inputs.
// - The port five direction register reads as all ones and all port five registers clear on reset.
module gp56_ports #(
	parameter WIDTH = 8
) (
	clk,
	reset,
	wb_cyc_i,
	wb_stb_i,
	wb_we_i,
	wb_adr_i,
	wb_sel_i,
	wb_dat_i,
	wb_dat_o,
	wb_ack_o,
	powerMode,
	p5PinIn,
	p5PinOut,
	p5PinOe_n,
	p5PullupOn,
	p6PinIn,
	p6PinOut,
	p6PinOe_n,
	extIrqIn,
	timerEventInput,
	converterExtTrigger
);
	input wire clk;
	input wire reset;
	input wire wb_cyc_i;
	input wire wb_stb_i;
	input wire wb_we_i;
	input wire [`GP56_ADR_W-1:0] wb_adr_i;
	input wire wb_sel_i;
	input wire [WIDTH-1:0] wb_dat_i;
	output reg [WIDTH-1:0] wb_dat_o;
	output reg wb_ack_o;
	input wire [`GP56_MODE_W-1:0] powerMode;
	input wire [WIDTH-1:0] p5PinIn;
	output reg [WIDTH-1:0] p5PinOut;
	output reg [WIDTH-1:0] p5PinOe_n;
	output reg [WIDTH-1:0] p5PullupOn;
	input wire [WIDTH-1:0] p6PinIn;
	output reg [WIDTH-1:0] p6PinOut;
	output reg [WIDTH-1:0] p6PinOe_n;
	output wire [WIDTH-1:0] extIrqIn;
	output wire timerEventInput;
	output wire converterExtTrigger;

	////////////////////////////////////////////////////////////////////////////////
	// registers

	reg [WIDTH-1:0] portFiveOutputLatch_r;
	reg [WIDTH-1:0] portFiveDirection_r;
	reg [WIDTH-1:0] portFivePullupCtrl_r;
	reg [WIDTH-1:0] portSixOutputLatch_r;
	reg [WIDTH-1:0] portSixDirection_r;
	wire [WIDTH-1:0] p5Sync;
	wire [WIDTH-1:0] p6Sync;
	wire busReq;
	wire wrEn;
	wire [WIDTH-1:0] p5ReadVal;
	wire [WIDTH-1:0] p6ReadVal;
	reg [WIDTH-1:0] readMux;
	wire [WIDTH-1:0] p5PullupLogic;
	wire resetState;
	reg holdState;
	reg floatState;
	// register selects
	wire selP5Latch;
	wire selP5Dir;
	wire selP5Pullup;
	wire selP6Latch;
	wire selP6Dir;
	genvar gi;

	// ack only on a fresh request, so it drops in the cycle after it was given
	assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wrEn = busReq & wb_we_i & wb_sel_i;

	// one select per register keeps every write decode a single compare;
	// unmapped addresses match none, so their writes fall away
	assign selP5Latch = (wb_adr_i == `GP56_P5_LATCH_OFS);
	assign selP5Dir = (wb_adr_i == `GP56_P5_DIR_OFS);
	assign selP5Pullup = (wb_adr_i == `GP56_P5_PULLUP_OFS);
	assign selP6Latch = (wb_adr_i == `GP56_P6_LATCH_OFS);
	assign selP6Dir = (wb_adr_i == `GP56_P6_DIR_OFS);

	gp56_pin_sync #(.WIDTH(WIDTH)) u_sync5 (
		.clk(clk),
		.reset(reset),
		.pinAsync(p5PinIn),
		.pinSync(p5Sync)
	);

	// port six pins feed only the read path
	gp56_pin_sync #(.WIDTH(WIDTH)) u_sync6 (
		.clk(clk),
		.reset(reset),
		.pinAsync(p6PinIn),
		.pinSync(p6Sync)
	);

	always @(posedge clk) begin
		if (reset) begin
			portFiveOutputLatch_r <= `GP56_REG_RESET;
		end else if (wrEn && selP5Latch) begin
			portFiveOutputLatch_r <= wb_dat_i;
		end
	end

	// port five direction clears
	// write-only: software cannot read it back, so it must reset cleanly
	always @(posedge clk) begin
		if (reset) begin
			portFiveDirection_r <= `GP56_REG_RESET;
		end else if (wrEn && selP5Dir) begin
			portFiveDirection_r <= wb_dat_i;
		end
	end

	// pull-ups off at reset
	// the control bit survives a switch to output; the drive logic masks it
	always @(posedge clk) begin
		if (reset) begin
			portFivePullupCtrl_r <= `GP56_REG_RESET;
		end else if (wrEn && selP5Pullup) begin
			portFivePullupCtrl_r <= wb_dat_i;
		end
	end

	// latch clears
	// a cleared latch means a pin turned to output starts low
	always @(posedge clk) begin
		if (reset) begin
			portSixOutputLatch_r <= `GP56_REG_RESET;
		end else if (wrEn && selP6Latch) begin
			portSixOutputLatch_r <= wb_dat_i;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			portSixDirection_r <= `GP56_REG_RESET;
		end else if (wrEn && selP6Dir) begin
			portSixDirection_r <= wb_dat_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read path

	// one slice per pin: read value and pull-up enable
	generate
		for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
			assign p5ReadVal[gi] = portFiveDirection_r[gi] ? portFiveOutputLatch_r[gi] :
				p5Sync[gi];
			assign p6ReadVal[gi] = portSixDirection_r[gi] ? portSixOutputLatch_r[gi] :
				p6Sync[gi];
			assign p5PullupLogic[gi] = ~portFiveDirection_r[gi] & portFivePullupCtrl_r[gi];
		end
	endgenerate

	always @* begin
		case (wb_adr_i)
			`GP56_P5_LATCH_OFS: readMux = p5ReadVal;
			`GP56_P5_DIR_OFS: readMux = `GP56_WO_READ;
			`GP56_P5_PULLUP_OFS: readMux = portFivePullupCtrl_r;
			`GP56_P6_LATCH_OFS: readMux = p6ReadVal;
			`GP56_P6_DIR_OFS: readMux = `GP56_WO_READ;
			default: readMux = `GP56_UNMAPPED_READ;
		endcase
	end

	// busReq needs ack low, so ack never lasts two cycles
	always @(posedge clk) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= busReq;
		end
	end

	// read data stands until the next request,
	// so a slow master can still take it after ack
	always @(posedge clk) begin
		if (reset) begin
			wb_dat_o <= `GP56_REG_RESET;
		end else if (busReq) begin
			wb_dat_o <= readMux;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin drive

	assign resetState = reset;

	// codes outside these four leave the pins fully functional;
	// hold and float never overlap, and reset outranks both below
	always @* begin
		holdState = 1'b0;
		floatState = 1'b0;
		case (powerMode)
			`GP56_MODE_SLEEP: begin
				holdState = 1'b1;
			end
			`GP56_MODE_SUBSLEEP: begin
				holdState = 1'b1;
			end
			`GP56_MODE_STANDBY: begin
				floatState = 1'b1;
			end
			`GP56_MODE_WATCH: begin
				floatState = 1'b1;
			end
			default: begin
				holdState = 1'b0;
				floatState = 1'b0;
			end
		endcase
	end

	// pin outputs are registered so sleep can simply stop updating them;
	// pins go high-impedance on the edge that samples reset
	always @(posedge clk) begin
		if (resetState) begin
			p5PinOut <= `GP56_REG_RESET;
			p5PinOe_n <= {WIDTH{1'b1}};
			p5PullupOn <= `GP56_REG_RESET;
		end else if (holdState) begin
			p5PinOut <= p5PinOut;
			p5PinOe_n <= p5PinOe_n;
			p5PullupOn <= p5PullupOn;
		end else if (floatState) begin
			p5PinOut <= p5PullupLogic;
			p5PinOe_n <= ~p5PullupLogic;
			p5PullupOn <= p5PullupLogic;
		end else begin
			p5PinOut <= portFiveOutputLatch_r;
			p5PinOe_n <= ~portFiveDirection_r;
			p5PullupOn <= p5PullupLogic;
		end
	end

	// port six has no pull-up, and keeps its normal drive in standby and watch
	always @(posedge clk) begin
		if (resetState) begin
			p6PinOut <= `GP56_REG_RESET;
			p6PinOe_n <= {WIDTH{1'b1}};
		end else if (holdState) begin
			p6PinOut <= p6PinOut;
			p6PinOe_n <= p6PinOe_n;
		end else begin
			p6PinOut <= portSixOutputLatch_r;
			p6PinOe_n <= ~portSixDirection_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// routed inputs

	// routing regardless of direction
	// an output pin therefore still raises its own interrupt input
	assign extIrqIn = p5Sync;
	assign timerEventInput = p5Sync[6];
	assign converterExtTrigger = p5Sync[5];
endmodule // gp56_ports

// >>> verilog/gp56_defines.vh
// register offsets, reset values and power mode codes for the two-port gpio block
`ifndef GP56_DEFINES_VH
`define GP56_DEFINES_VH
`define GP56_ADR_W 16
`define GP56_P5_LATCH_OFS 16'hffd8
`define GP56_P5_DIR_OFS 16'hffe8
`define GP56_P5_PULLUP_OFS 16'hffef
`define GP56_P6_LATCH_OFS 16'hffd9
`define GP56_P6_DIR_OFS 16'hffe9
`define GP56_REG_RESET 8'h00
`define GP56_WO_READ 8'hff
`define GP56_UNMAPPED_READ 8'h00
`define GP56_MODE_W 3
`define GP56_MODE_ACTIVE 3'h0
`define GP56_MODE_SUBACTIVE 3'h1
`define GP56_MODE_SLEEP 3'h2
`define GP56_MODE_SUBSLEEP 3'h3
`define GP56_MODE_STANDBY 3'h4
`define GP56_MODE_WATCH 3'h5
`define GP56_SYNC_STAGES 2
`endif

// >>> verilog/gp56_pin_sync.v
// two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module gp56_pin_sync #(
	parameter WIDTH = 8
) (
	clk,
	reset,
	pinAsync,
	pinSync
);
	input wire clk;
	input wire reset;
	input wire [WIDTH-1:0] pinAsync;
	output wire [WIDTH-1:0] pinSync;

	reg [WIDTH-1:0] stage1_r;
	reg [WIDTH-1:0] stage2_r;

	// first stage is read only by the second
	always @(posedge clk) begin
		if (reset) begin
			stage1_r <= {WIDTH{1'b0}};
			stage2_r <= {WIDTH{1'b0}};
		end else begin
			stage1_r <= pinAsync;
			stage2_r <= stage1_r;
		end
	end

	assign pinSync = stage2_r;
endmodule // gp56_pin_sync

// >>> dv/gp56_ports_properties.sv
// assertions on the gpio block ports
`timescale 1ns/1ps
module gp56_ports_props #(
	parameter WIDTH = 8
) (
	input wire clk,
	input wire reset,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [15:0] wb_adr_i,
	input wire [WIDTH-1:0] wb_dat_o,
	input wire wb_ack_o,
	input wire [2:0] powerMode,
	input wire [WIDTH-1:0] p5PinIn,
	input wire [WIDTH-1:0] p5PinOe_n,
	input wire [WIDTH-1:0] p5PullupOn,
	input wire [WIDTH-1:0] p6PinOut,
	input wire [WIDTH-1:0] p6PinOe_n,
	input wire [WIDTH-1:0] extIrqIn
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_wo_rd;
		!wb_we_i && (wb_adr_i == 16'hffe8 || wb_adr_i == 16'hffe9);
	endsequence
	a_ack_pulse: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not one cycle");
	a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	a_wo_ones: assert property (s_req ##0 s_wo_rd |=> wb_dat_o == '1)
		else $error("direction read not ones");
	a_pullup_input: assert property (powerMode == 3'h0 && $past(powerMode) == 3'h0 |->
		(p5PullupOn & ~p5PinOe_n) == '0)
		else $error("pullup on driven pin");
	a_pin_sync: assert property (!$past(reset) && !$past(reset, 2) |->
		extIrqIn == $past(p5PinIn, 2))
		else $error("interrupt input latency");
	a_reset_float: assert property ($fell(reset) |-> p5PinOe_n == '1 && p6PinOe_n == '1)
		else $error("pins driven after reset");
	a_reset_pullup: assert property ($fell(reset) |-> p5PullupOn == '0)
		else $error("pullup on after reset");
	// sleep freezes outputs, even across register writes
	a_sleep_hold: assert property (!$past(reset) && $past(powerMode) inside {3'h2, 3'h3} |->
		$stable(p6PinOut) && $stable(p5PinOe_n))
		else $error("pins moved in sleep");
endmodule // gp56_ports_props
////////////////////////////////////////////////////////////////
bind gp56_ports gp56_ports_props #(.WIDTH(WIDTH)) gp56_ports_props_inst (.*);

// >>> dv/gp56_board.sv
// board model giving the pin levels of both ports
`timescale 1ns/1ps
module gp56_board (
	input logic [7:0] out5,
	input logic [7:0] oe5_n,
	input logic [7:0] out6,
	input logic [7:0] oe6_n,
	input logic [7:0] ext5,
	input logic [7:0] ext6,
	output logic [7:0] pin5,
	output logic [7:0] pin6
);
	// driven pins win
	// the board yields where the device drives, so contention is never modelled
	assign pin5 = ~oe5_n & out5 | oe5_n & ext5;
	assign pin6 = ~oe6_n & out6 | oe6_n & ext6;
endmodule // gp56_board

// >>> dv/gp56_ports_tb_top.sv
// bench for the two-port gpio block
`timescale 1ns/1ps
module gp56_ports_tb_top;
	logic clk = 0, reset = 1, cyc = 0, stb = 0, we = 0, sel = 0;
	logic [15:0] adr = 0;
	logic [7:0] dat = 0, e5 = 8'h5a, e6 = 8'ha5, q, h6, l5 = 0, d5 = 0, u5 = 0, l6 = 0, d6 = 0;
	logic [2:0] mode = 0;
	wire [7:0] p5, p6, dO, o5, oe5, pu, o6, oe6, irq;
	wire ack, tev, cvt;
	int n_errors = 0, n_checks = 0, seed = 73375;
	gp56_ports gp56_ports_inst (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dO),
		.wb_ack_o(ack), .powerMode(mode), .p5PinIn(p5), .p5PinOut(o5), .p5PinOe_n(oe5),
		.p5PullupOn(pu), .p6PinIn(p6), .p6PinOut(o6), .p6PinOe_n(oe6), .extIrqIn(irq),
		.timerEventInput(tev), .converterExtTrigger(cvt));
	gp56_board gp56_board_inst (.out5(o5), .oe5_n(oe5), .out6(o6), .oe6_n(oe6), .ext5(e5),
		.ext6(e6), .pin5(p5), .pin6(p6));
	initial forever #2 clk = ~clk;
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(string nm, logic [7:0] s, logic [7:0] x);
		n_checks++;
		if (s !== x) begin
			n_errors++;
			$display("unexpected %s exp %h seen %h", nm, x, s);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic bus(logic w, logic [15:0] a, logic [7:0] d, logic sl = 1);
		int k;
		{cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, sl};
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 50);
		q = dO;
		{cyc, stb} <= 2'b00;
		@(posedge clk);
		if (k == 50) begin
			n_errors++;
			conclude();
		end
	endtask
	task automatic wr(logic [15:0] a, logic [7:0] d, logic sl = 1);
		bus(1, a, d, sl);
		if (sl)
			case (a)
				16'hffd8: l5 = d;
				16'hffe8: d5 = d;
				16'hffef: u5 = d;
				16'hffd9: l6 = d;
				16'hffe9: d6 = d;
			endcase
	endtask
	task automatic rd(logic [15:0] a, logic [7:0] x);
		bus(0, a, 0);
		chk("read", q, x);
	endtask
	task automatic ck();
		logic [7:0] m5, m6;
		m5 = d5 & l5 | ~d5 & e5;
		m6 = d6 & l6 | ~d6 & e6;
		repeat (4) @(posedge clk);
		rd(16'hffd8, m5);
		rd(16'hffe8, 8'hff);
		rd(16'hffef, u5);
		rd(16'hffd9, m6);
		rd(16'hffe9, 8'hff);
		rd(16'hfff0, 8'h00);
		chk("irq", irq, m5);
		chk("route", {6'h0, tev, cvt}, {6'h0, m5[6:5]});
		chk("pullup", pu, ~d5 & u5);
		chk("oe5", oe5, ~d5);
		chk("oe6", oe6, ~d6);
		chk("out6", o6, l6);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		reset <= 0;
		for (int t = 0; t < 30; t++) begin
			ck();
			e5 <= rnd();
			e6 <= rnd();
			wr(16'hffd8, rnd());
			wr(16'hffe8, rnd());
			wr(16'hffef, rnd());
			wr(16'hffd9, rnd());
			wr(16'hffe9, rnd());
			wr(16'hffd9, rnd(), 1'b0);
			$display("test %0d done", t);
		end
		wr(16'hffe9, 8'hff);
		for (int md = 0; md < 6; md++) begin
			mode <= 3'(md);
			h6 = o6;
			wr(16'hffd9, ~l6);
			repeat (2) @(posedge clk);
			chk("hold", o6, md inside {2, 3} ? h6 : l6);
			chk("standby", oe5, md > 3 ? ~(~d5 & u5) : ~d5);
			chk("pulled", o5 & ~oe5, md > 3 ? ~d5 & u5 : d5 & l5);
		end
		$display("mode test done");
		// a second reset in mid-run must clear every register again
		{mode, reset} <= {3'h0, 1'b1};
		repeat (4) @(posedge clk);
		reset <= 0;
		{l5, d5, u5, l6, d6} = 0;
		ck();
		$display("reset test done");
		conclude();
	end
endmodule // gp56_ports_tb_top
